// [common/adc_fifo_pkg.sv]
// constants and carrier types for the converter output fifo block
package adc_fifo_pkg;
	localparam int data_w = 18;
	localparam int depth_w = 3;
	localparam int max_words = 14;
	localparam int ptr_w = 4;
	localparam logic [9:0] period_off_clks = 10'h020;
	localparam logic [9:0] period_unit_clks = 10'h040;
	localparam logic [9:0] period_skip_clks = 10'h200;
	localparam logic [6:0] settle_clks = 7'h2E;
	localparam logic [9:0] sample_spacing = 10'h020;
	localparam logic [ptr_w-1:0] ptr_zero = 4'h0;

	typedef enum logic [1:0]
	{
		st_down = 2'b00,
		st_settle = 2'b01,
		st_run = 2'b11,
		st_hung = 2'b10
	} mode_e;

	typedef struct packed
	{
		logic [data_w-1:0] word;
	} sample_s;

	typedef struct packed
	{
		logic read_n;
		logic select_n;
	} host_strobe_s;
endpackage

// [core/adc_output_fifo.sv]
// output fifo, ready pacing and power-down sequencing of the converter
module adc_output_fifo
(
	input wire logic clk_sys, // converter clock
	input wire logic rst, // async reset, active high
	input wire logic reset_n, // device reset pin
	input wire logic power_down_n, // power-down pin, low stops when power_down_driven is high
	input wire logic power_down_driven, // pin actually driven
	input wire logic [2:0] fifo_depth_select, // depth select pins
	input wire adc_fifo_pkg::host_strobe_s strobe, // read and select
	input wire adc_fifo_pkg::sample_s conv_data, // filter output
	output logic sample_ready_n, // ready pulse, high pulse
	output adc_fifo_pkg::sample_s dout, // parallel output word
	output logic dout_oe, // data pins driven
	output logic reference_on // reference and analog enabled
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed
	{
		adc_fifo_pkg::mode_e mode;
		logic [6:0] settle;
		logic [9:0] tick;
		logic [9:0] period;
		logic [1:0][adc_fifo_pkg::max_words-1:0][adc_fifo_pkg::data_w-1:0] mem;
		logic [adc_fifo_pkg::ptr_w-1:0] fill;
		logic [adc_fifo_pkg::ptr_w-1:0] rd_ptr;
		logic full;
		logic bank;
		logic read_seen;
		logic need_rd;
		logic rd_prev;
		logic ready_n;
		logic [adc_fifo_pkg::data_w-1:0] dout;
		logic oe;
		logic ref_on;
	} core_s;

	core_s state;
	core_s next_state;

	logic pd_active;
	logic [3:0] level;
	logic [9:0] level_period;
	logic rd_fall;
	logic skid_in_valid;
	logic skid_in_ready;
	logic skid_out_valid;
	logic skid_take;
	adc_fifo_pkg::sample_s skid_out;
	logic [9:0] spacing;

	assign pd_active = power_down_driven && !power_down_n;
	assign level = {fifo_depth_select, 1'b0};
	assign level_period = (fifo_depth_select == 3'h0) ? adc_fifo_pkg::period_off_clks
		: 10'(adc_fifo_pkg::period_unit_clks * fifo_depth_select);
	assign rd_fall = state.rd_prev && !strobe.read_n && !strobe.select_n;
	assign spacing = state.tick % adc_fifo_pkg::sample_spacing;
	assign skid_in_valid = (state.mode == adc_fifo_pkg::st_run) && spacing == 10'h000;
	assign skid_take = skid_out_valid && !state.full && state.mode == adc_fifo_pkg::st_run;

	// ----------------------------------------
	// input buffer
	// ----------------------------------------
	skid_buffer u_skid
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(state.mode != adc_fifo_pkg::st_run),
		.in_data(conv_data),
		.in_valid(skid_in_valid),
		.in_ready(skid_in_ready),
		.out_data(skid_out),
		.out_valid(skid_out_valid),
		.out_ready(skid_take)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.rd_prev = strobe.read_n;
		next_state.ready_n = 1'b0;
		case (state.mode)
			adc_fifo_pkg::st_down:
			begin
				next_state.ref_on = 1'b0;
				next_state.oe = 1'b0;
				if (!pd_active && reset_n && !strobe.read_n)
				begin
					next_state.mode = adc_fifo_pkg::st_settle;
					next_state.settle = 7'h00;
					next_state.ref_on = 1'b1;
				end
			end
			adc_fifo_pkg::st_settle:
			begin
				next_state.settle = state.settle + 7'h01;
				if (state.settle == adc_fifo_pkg::settle_clks - 7'h01)
				begin
					next_state.mode = adc_fifo_pkg::st_run;
					next_state.tick = 10'h000;
					next_state.fill = adc_fifo_pkg::ptr_zero;
					next_state.period = level_period;
				end
			end
			adc_fifo_pkg::st_run:
			begin
				next_state.tick = state.tick + 10'h001;
				if (skid_take)
				begin
					next_state.mem[state.bank][state.fill] = skid_out.word;
					next_state.fill = state.fill + 4'h1;
				end
				if (skid_take && (state.fill + 4'h1 >= level || level == 4'h0))
				begin
					next_state.full = 1'b1;
				end
				if (state.tick + 10'h001 >= state.period)
				begin
					next_state.tick = 10'h000;
					next_state.ready_n = state.full || level == 4'h0;
					next_state.rd_ptr = adc_fifo_pkg::ptr_zero;
					next_state.read_seen = 1'b0;
					next_state.period = level_period;
					if (state.full)
					begin
						next_state.full = 1'b0;
						next_state.fill = adc_fifo_pkg::ptr_zero;
						// fill the other bank while the host reads this one
						next_state.bank = ~state.bank;
						if (!state.read_seen && level != 4'h0)
						begin
							next_state.period = adc_fifo_pkg::period_skip_clks;
						end
					end
				end
				if (rd_fall)
				begin
					next_state.dout = state.mem[~state.bank][state.rd_ptr];
					next_state.oe = 1'b1;
					next_state.rd_ptr = state.rd_ptr + 4'h1;
					next_state.read_seen = 1'b1;
					if (level != 4'h0 && state.rd_ptr >= level)
					begin
						next_state.mode = adc_fifo_pkg::st_hung;
					end
				end
				if (strobe.read_n)
				begin
					next_state.oe = 1'b0;
				end
				if (state.read_seen)
				begin
					next_state.period = level_period;
				end
			end
			adc_fifo_pkg::st_hung:
			begin
				next_state.oe = 1'b0;
			end
			default:
			begin
				next_state.mode = adc_fifo_pkg::st_down;
			end
		endcase
		if (pd_active || !reset_n)
		begin
			next_state.mode = adc_fifo_pkg::st_down;
			next_state.ready_n = 1'b0;
			next_state.oe = 1'b0;
			next_state.full = 1'b0;
			next_state.fill = adc_fifo_pkg::ptr_zero;
			next_state.read_seen = 1'b0;
			next_state.ref_on = !pd_active;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign sample_ready_n = state.ready_n;
	assign dout = state.dout;
	assign dout_oe = state.oe;
	assign reference_on = state.ref_on;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_PD_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
		pd_active |=> !sample_ready_n && !reference_on && !dout_oe)
		else $error("activity while powered down");
	AST_SETTLE_LEN: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(state.mode == adc_fifo_pkg::st_run) |-> $past(state.settle) == adc_fifo_pkg::settle_clks - 7'h01)
		else $error("settling length wrong");
	AST_NO_READY_SETTLE: assert property (@(posedge clk_sys) disable iff (rst)
		state.mode != adc_fifo_pkg::st_run |=> !sample_ready_n)
		else $error("ready outside run");
	AST_READ_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
		rd_fall && state.mode == adc_fifo_pkg::st_run && reset_n && !pd_active |=> dout_oe)
		else $error("read did not drive data");
	AST_UNDRIVEN_PD: assert property (@(posedge clk_sys) disable iff (rst)
		!power_down_driven && !power_down_n && reset_n && state.mode != adc_fifo_pkg::st_down
		|=> state.mode != adc_fifo_pkg::st_down)
		else $error("floating pin powered down");
	AST_PERIOD_BOUND: assert property (@(posedge clk_sys) disable iff (rst)
		state.mode == adc_fifo_pkg::st_run |-> state.period <= adc_fifo_pkg::period_skip_clks)
		else $error("period out of range");
	AST_READY_ONE: assert property (@(posedge clk_sys) disable iff (rst)
		sample_ready_n |=> !sample_ready_n)
		else $error("ready pulse too long");
	AST_DEPTH_NOW: assert property (@(posedge clk_sys) disable iff (rst)
		state.mode == adc_fifo_pkg::st_run && state.read_seen && reset_n && !pd_active
		&& state.tick + 10'h001 < state.period |=> state.period == $past(level_period))
		else $error("depth change not applied");
endmodule

// [core/skid_buffer.sv]
// two-entry buffer with valid and ready on both sides
module skid_buffer
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic flush, // drop held words
	input wire adc_fifo_pkg::sample_s in_data, // word from converter
	input wire logic in_valid, // word offered
	output logic in_ready, // space available
	output adc_fifo_pkg::sample_s out_data, // oldest word
	output logic out_valid, // word held
	input wire logic out_ready // drain accepts
);
	typedef struct packed
	{
		adc_fifo_pkg::sample_s [1:0] mem;
		logic [1:0] count;
	} skid_s;

	skid_s state;
	skid_s next_state;

	always_comb
	begin
		next_state = state;
		if (flush)
		begin
			next_state.count = 2'h0;
		end
		else
		begin
			if (out_ready && state.count != 2'h0)
			begin
				next_state.mem[0] = state.mem[1];
				next_state.count = state.count - 2'h1;
			end
			if (in_valid && state.count != 2'h2)
			begin
				next_state.mem[next_state.count[0]] = in_data;
				next_state.count = next_state.count + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign in_ready = (state.count != 2'h2);
	assign out_valid = (state.count != 2'h0);
	assign out_data = state.mem[0];
endmodule

// [test/adc_output_fifo_level_and_powerdown_tb.sv]
// self-checking bench of the converter output fifo
module adc_output_fifo_level_and_powerdown_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst = 1'b1, reset_n = 1'b0, power_down_n = 1'b1, power_down_driven = 1'b1;
	logic clk_stop = 1'b0;
	logic [2:0] fifo_depth_select = 3'h1;
	adc_fifo_pkg::sample_s conv_data = '0;
	adc_fifo_pkg::host_strobe_s strobe;
	adc_fifo_pkg::sample_s dout;
	logic sample_ready_n, dout_oe, reference_on;
	integer seed = 32'h8B8EC885;
	int fails = 0, n_checks = 0, cyc = 0, t, t0, k, d;
	always #2 clk_sys = ~clk_sys & ~clk_stop;
	always @(posedge clk_sys) cyc <= cyc + 1;
	// ramp input: stored words must step by the sample spacing
	always @(posedge clk_sys) conv_data.word <= #1 conv_data.word + 18'h00001;
	adc_output_fifo dut (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .power_down_n(power_down_n),
		.power_down_driven(power_down_driven), .fifo_depth_select(fifo_depth_select), .strobe(strobe),
		.conv_data(conv_data), .sample_ready_n(sample_ready_n), .dout(dout), .dout_oe(dout_oe),
		.reference_on(reference_on));
	host_model host (.clk_sys(clk_sys), .dout_oe(dout_oe), .dout(dout), .strobe(strobe));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_ready(input int cap);
		t = -1;
		repeat (cap)
		begin
			@(posedge clk_sys);
			#1;
			if (sample_ready_n === 1'b1)
			begin
				t = cyc;
				return;
			end
		end
	endtask
	task automatic bring_up(input logic [2:0] sel);
		@(posedge clk_sys);
		#1 reset_n = 1'b0;
		fifo_depth_select = sel;
		repeat (4) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		host.rd(1);
		host.got.delete();
		t0 = cyc;
		wait_ready(2000);
		check("settle", 32'(t - t0 >= 46), 32'h1);
	endtask
	task automatic burst(input int n);
		host.rd(n);
		k = 0;
		foreach (host.got[i])
		begin
			k += int'(host.got[i] != -1);
			check("word", 32'(host.got[i]), 32'(host.got[0] + 32 * i));
		end
		check("count", 32'(k), 32'(n));
		host.got.delete();
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#1 rst = 1'b0;
		for (d = 0; d < 8; d++)
		begin
			bring_up(3'(d));
			host.stray();
			check("unselected", 32'(host.got.pop_front()), 32'hFFFFFFFF);
			burst(d == 0 ? 1 : 2 * d);
			t0 = t;
			wait_ready(1000);
			check("period", 32'(t - t0), 32'(d == 0 ? 32 : 64 * d));
		end
		bring_up(3'(1 + $unsigned($random(seed)) % 7));
		t0 = t;
		wait_ready(1000);
		check("skip period", 32'(t - t0), 32'd512);
		bring_up(3'h2);
		host.rd(1);
		#1 fifo_depth_select = 3'h4;
		host.rd(3);
		host.got.delete();
		wait_ready(1000);
		burst(8);
		t0 = t;
		wait_ready(1000);
		check("new period", 32'(t - t0), 32'd256);
		host.rd(9);
		host.got.delete();
		wait_ready(600);
		check("over-read hangs", 32'(t), 32'hFFFFFFFF);
		power_down_n = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 check("reference", 32'(reference_on), 32'h0);
		wait_ready(300);
		check("down quiet", 32'(t), 32'hFFFFFFFF);
		clk_stop = 1'b1;
		#400 clk_stop = 1'b0;
		@(posedge clk_sys);
		#1 check("halted", 32'({reference_on, dout_oe, sample_ready_n}), 32'h0);
		power_down_n = 1'b1;
		bring_up(3'h1);
		check("reference", 32'(reference_on), 32'h1);
		power_down_driven = 1'b0;
		power_down_n = 1'b0;
		wait_ready(600);
		check("undriven", 32'({reference_on, t != -1}), 32'h3);
		wrap_up();
	end
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule

// [test/host_model.sv]
// host side reader of the converter output words
module host_model
(
	input wire logic clk_sys, // converter clock
	input wire logic dout_oe, // data pins driven
	input wire adc_fifo_pkg::sample_s dout, // parallel word
	output adc_fifo_pkg::host_strobe_s strobe // read and select
);
	timeunit 1ns;
	timeprecision 1ps;
	int got[$];
	initial strobe = '{read_n: 1'b1, select_n: 1'b0};
	// one read pulse per word, word taken two edges after the fall
	task automatic rd(input int k);
		repeat (k)
		begin
			@(posedge clk_sys);
			#1 strobe.read_n = 1'b0;
			repeat (2) @(posedge clk_sys);
			#1 got.push_back(dout_oe ? int'(dout.word) : -1);
			strobe.read_n = 1'b1;
			@(posedge clk_sys);
		end
	endtask
	// read pulse with the decoded select left high, must be ignored
	task automatic stray();
		@(posedge clk_sys);
		#1 strobe.select_n = 1'b1;
		strobe.read_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 got.push_back(dout_oe ? int'(dout.word) : -1);
		strobe.read_n = 1'b1;
		strobe.select_n = 1'b0;
		@(posedge clk_sys);
	endtask
endmodule
